// [bench/watchdog_control_registers_test.sv]
/*
  Self-checking bench for the watchdog control register block.
  Assumes the block answers APB with one wait state and samples its
  fuse inputs only while sys_rst_i is high.
*/
`timescale 1ns/100ps
`default_nettype none
module watchdog_control_registers_test;
  logic        mclk_i = 0, sys_rst_i = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic [3:0]  pstrb = 4'h0;
  logic        pready, pslverr, err, f_en = 0, f_win = 0, low_power_rc_osc = 0;
  logic [4:0]  f_run = 5'h04, f_slp = 5'h01;
  logic [1:0]  f_src = 2'h0;
  logic        sleep = 0, idle = 0, low_power_rc_osc_run = 0;
  logic        running, dev_rst, wake, irq;
  int          num_errors = 0, compares = 0, n_rst = 0, n_wake = 0;

  watchdog_control_registers uut (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .fuse_enable_i(f_en),
    .fuse_run_postscaler_i(f_run), .fuse_sleep_postscaler_i(f_slp),
    .fuse_run_clock_source_i(f_src), .fuse_window_i(f_win),
    .low_power_rc_osc_i(low_power_rc_osc), .fast_rc_osc_i(1'b0),
    .sleep_mode_i(sleep), .idle_mode_i(idle),
    .watchdog_running_o(running), .device_reset_o(dev_rst),
    .wake_o(wake), .irq_o(irq));

  // The 8 ns bus clock.
  initial begin
    forever #4 mclk_i = ~mclk_i;
  end

  // Pulses are counted at the edge that samples them.
  always @(posedge mclk_i) begin
    if (dev_rst === 1'b1) n_rst++;
    if (wake === 1'b1) n_wake++;
  end

  // Slow oscillator, far below a quarter of the bus clock.
  always begin
    repeat (5) @(posedge mclk_i);
    if (low_power_rc_osc_run) low_power_rc_osc <= ~low_power_rc_osc;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // One APB transfer; the request is held until pready is sampled high.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk_i);
    psel <= 1; penable <= 0; pwrite <= wr; paddr <= a;
    pwdata <= d; pstrb <= wr ? s : 4'h0;
    @(posedge mclk_i);
    penable <= 1;
    do begin
      @(posedge mclk_i);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  function automatic logic [31:0] ctrl(logic en, logic [4:0] run,
                                       logic [1:0] src, logic [4:0] slp,
                                       logic win);
    return {16'h0000, en, 2'b00, run, src, slp, win};
  endfunction : ctrl

  // Fuses only load while reset is held, so each set needs a reset.
  task automatic do_reset(input logic en, input logic [4:0] run,
                          input logic [1:0] src, input logic [4:0] slp,
                          input logic win);
    f_en <= en; f_run <= run; f_src <= src; f_slp <= slp; f_win <= win;
    sys_rst_i <= 1;
    repeat (5) @(posedge mclk_i);
    sys_rst_i <= 0;
  endtask : do_reset

  // Every clock source code, with status fields that ignore writes.
  task automatic test_fields();
    logic [31:0] e;
    for (int i = 0; i < 4; i++) begin
      do_reset(i == 3, 5'(i * 10 + 1), 2'(i), 5'(30 - i * 10), i == 3);
      e = ctrl(i == 3, 5'(i * 10 + 1), 2'(i), 5'(30 - i * 10), i == 3);
      apb(0, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h0);
      check(rd, e);
      apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0000_6000, 4'h3);
      apb(0, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h0);
      check(rd, e);
      check(32'(running), 32'(i == 3));
      apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5744, 4'h3);
    end
  endtask : test_fields

  // Software enable, window bit, and the clear key.
  task automatic test_enable_key();
    do_reset(0, 5'h04, 2'h0, 5'h01, 0);
    apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0000_0001, 4'h1);
    apb(0, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h0);
    check(rd, 32'h0000_0403);
    apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0000_8000, 4'h3);
    apb(0, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h0);
    check(rd, 32'h0000_8402);
    n_rst = 0;
    repeat (10) apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5743, 4'h3);
    check(32'(n_rst), 32'h0);
    apb(0, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h0, 4'h0);
    check(rd, 32'h0);
    n_rst = 0;
    repeat (10) apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5743, 4'h1);
    check(32'(n_rst != 0), 32'h1);
    n_rst = 0;
    repeat (10) apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5744, 4'h3);
    check(32'(n_rst != 0), 32'h1);
    // With window mode on, a key soon after a restart is an early clear.
    apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5743, 4'h3);
    apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0000_8001, 4'h3);
    n_rst = 0;
    repeat (2) apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5743, 4'h3);
    repeat (2) @(posedge mclk_i);
    check(32'(n_rst), 32'h1);
    apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h3);
    // Software keeps off the bus just after a disable.
    repeat (2) @(posedge mclk_i);
    check(32'(running), 32'h0);
  endtask : test_enable_key

  // Timeout flag, sticky status, mask and the unmapped hole.
  task automatic test_status();
    apb(0, wdt_ctrl_pkg::RESET_CAUSE_ADDR, 32'h0, 4'h0);
    check(rd, 32'h1);
    apb(1, wdt_ctrl_pkg::RESET_CAUSE_ADDR, 32'h1, 4'hf);
    apb(0, wdt_ctrl_pkg::RESET_CAUSE_ADDR, 32'h0, 4'h0);
    check(rd, 32'h0);
    apb(0, wdt_ctrl_pkg::IRQ_STATUS_ADDR, 32'h0, 4'h0);
    check(rd, 32'h5);
    check(32'(irq), 32'h0);
    apb(1, wdt_ctrl_pkg::IRQ_MASK_ADDR, 32'h1, 4'hf);
    repeat (2) @(posedge mclk_i);
    check(32'(irq), 32'h1);
    apb(1, wdt_ctrl_pkg::IRQ_STATUS_ADDR, 32'h1, 4'hf);
    repeat (2) @(posedge mclk_i);
    check(32'(irq), 32'h0);
    apb(0, 12'h020, 32'h0, 4'h0);
    check({rd[30:0], err}, 32'h1);
  endtask : test_status

  // Sleep and idle count only slow oscillator edges.
  task automatic test_sleep();
    for (int m = 0; m < 2; m++) begin
      apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0000_8000, 4'h3);
      apb(1, wdt_ctrl_pkg::CLEAR_KEY_ADDR, 32'h5743, 4'h3);
      repeat (3) @(posedge mclk_i);
      sleep <= (m == 0);
      idle <= (m == 1);
      n_rst = 0;
      n_wake = 0;
      repeat (40) @(posedge mclk_i);
      check(32'(n_wake), 32'h0);
      low_power_rc_osc_run <= 1;
      repeat (60) @(posedge mclk_i);
      check(32'(n_wake != 0), 32'h1);
      check(32'(n_rst), 32'h0);
      low_power_rc_osc_run <= 0;
      sleep <= 0;
      idle <= 0;
      apb(1, wdt_ctrl_pkg::CTRL_LOW_ADDR, 32'h0, 4'h3);
      repeat (2) @(posedge mclk_i);
    end
  endtask : test_sleep

  task automatic tally_and_finish();
    $display("Comparisons %0d, errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Main sequence.
  initial begin
    test_fields();
    test_enable_key();
    test_status();
    test_sleep();
    tally_and_finish();
  end

  // The tests need about 520 cycles; this cuts a hang short.
  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    tally_and_finish();
  end
endmodule : watchdog_control_registers_test
`default_nettype wire

// [hw/watchdog_control_registers.sv]
/*
  Watchdog control and status registers with the watchdog counter, an
  APB slave for software, sticky interrupt status and a reset cause flag.
  Assumes fuse inputs are static, sys_rst_i is the power-on reset held
  for at least three clocks, and power mode inputs share mclk_i.
*/
//
// Contract
// RULE1: Writing one to the enable bit starts a watchdog not fuse enabled.
// RULE2: Writing zero stops only a software enable, never a fuse enable.
// RULE3: The enable bit reads one whenever the watchdog runs.
// RULE4: The run postscaler divides the watchdog clock by two to its value.
// RULE5: The run clock source field encodes low power RC, fast RC, reserved, system clock.
// RULE6: The sleep postscaler sets the sleep and idle timeout the same way.
// RULE7: Postscaler and clock source fields mirror fuses loaded at power on.
// RULE8: The lowest control bit turns window mode on or off.
// RULE9: A set window fuse forces window mode, else it is a software bit.
// RULE10: Software leaves the block alone in the cycle after clearing enable.
// RULE11: The key written in one 16-bit write restarts the counter.
// RULE12: Bits 14 and 13 of the low control register read zero.
// RULE13: In sleep and idle the counter runs from the low power RC.
// RULE14: A timeout reset sets the timeout flag in the reset cause register.
// RULE15: Software waits two watchdog clocks after a clear before power save.
// RULE16: Other values or byte writes to the key do nothing; it reads zero.
`timescale 1ns/100ps
`default_nettype none
module watchdog_control_registers (
  // Clock and reset.
  input  wire logic        mclk_i,
  input  wire logic        sys_rst_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [3:0]  pstrb_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Configuration fuses.
  input  wire logic        fuse_enable_i,
  input  wire logic [4:0]  fuse_run_postscaler_i,
  input  wire logic [4:0]  fuse_sleep_postscaler_i,
  input  wire logic [1:0]  fuse_run_clock_source_i,
  input  wire logic        fuse_window_i,
  // Oscillator pins.
  input  wire logic        low_power_rc_osc_i,
  input  wire logic        fast_rc_osc_i,
  // Power mode from the power manager.
  input  wire logic        sleep_mode_i,
  input  wire logic        idle_mode_i,
  // Watchdog results.
  output logic             watchdog_running_o,
  output logic             device_reset_o,
  output logic             wake_o,
  output logic             irq_o
);

  // Counter limit for a postscaler setting: two to the value, less one.
  function automatic logic [31:0] period_limit(input logic [4:0] div);
    period_limit = (32'h0000_0001 << div) - 32'h0000_0001;
  endfunction : period_limit

  localparam int OSC_W = wdt_ctrl_pkg::OSC_COUNT;
  localparam int IRQ_W = wdt_ctrl_pkg::IRQ_WIDTH;
  logic [4:0]           cfg_run_sync1;
  logic [4:0]           cfg_run_sync2;
  logic [4:0]           cfg_sleep_sync1;
  logic [4:0]           cfg_sleep_sync2;
  logic [1:0]           cfg_src_sync1;
  logic [1:0]           cfg_src_sync2;
  logic [1:0]           cfg_flag_sync1;
  logic [1:0]           cfg_flag_sync2;
  logic [4:0]           run_postscaler;
  logic [4:0]           sleep_postscaler;
  logic [1:0]           run_clock_source;
  logic                 fuse_enable;
  logic                 fuse_window;
  logic                 sw_enable;
  logic                 sw_window;
  logic                 running;
  logic                 window_mode_enable;
  logic [OSC_W-1:0]     osc_pins;
  logic [OSC_W-1:0]     osc_rise;
  logic                 low_power;
  logic                 wdt_tick;
  logic [31:0]          count;
  logic [31:0]          limit;
  logic                 bus_access;
  logic                 wr_fire;
  logic                 key_write;
  logic                 early_clear;
  logic                 key_restart;
  logic                 timeout;
  logic [IRQ_W-1:0]     irq_status;
  logic [IRQ_W-1:0]     irq_mask;
  logic [IRQ_W-1:0]     irq_events;
  logic [IRQ_W-1:0]     next_irq_status;
  logic                 timeout_reset_flag;
  logic [31:0]          next_rdata;
  logic                 next_slverr;

  // Fuse pins are static, but they still pass two stages before use.
  always_ff @(posedge mclk_i) begin
    cfg_run_sync1   <= fuse_run_postscaler_i;
    cfg_run_sync2   <= cfg_run_sync1;
    cfg_sleep_sync1 <= fuse_sleep_postscaler_i;
    cfg_sleep_sync2 <= cfg_sleep_sync1;
    cfg_src_sync1   <= fuse_run_clock_source_i;
    cfg_src_sync2   <= cfg_src_sync1;
    cfg_flag_sync1  <= {fuse_window_i, fuse_enable_i};
    cfg_flag_sync2  <= cfg_flag_sync1;
  end

  // Fuse values are caught while reset is held, so the latest sample wins
  // at release and software can never change them afterwards.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      run_postscaler   <= cfg_run_sync2;   // RULE4 RULE7
      sleep_postscaler <= cfg_sleep_sync2; // RULE6 RULE7
      run_clock_source <= cfg_src_sync2;   // RULE5 RULE7
      fuse_enable      <= cfg_flag_sync2[0];
      fuse_window      <= cfg_flag_sync2[1];
    end
  end

  // Oscillator pins, one synchroniser each.
  assign osc_pins[wdt_ctrl_pkg::OSC_LOW_POWER_RC] = low_power_rc_osc_i;
  assign osc_pins[wdt_ctrl_pkg::OSC_FAST_RC]      = fast_rc_osc_i;
  generate
    for (genvar i = 0; i < OSC_W; i++) begin : g_osc
      wdt_osc_edge u_edge (
        .mclk_i   (mclk_i),
        .sys_rst_i(sys_rst_i),
        .osc_i    (osc_pins[i]),
        .rise_o   (osc_rise[i])
      );
    end
  endgenerate

  // Tick source; the reserved code yields no tick and freezes the count.
  assign low_power = sleep_mode_i | idle_mode_i;
  always_comb begin
    wdt_tick = 1'b0;
    if (low_power) begin
      wdt_tick = osc_rise[wdt_ctrl_pkg::OSC_LOW_POWER_RC]; // RULE13
    end else begin
      case (run_clock_source) // RULE5
        wdt_ctrl_pkg::SRC_LOW_POWER_RC:
          wdt_tick = osc_rise[wdt_ctrl_pkg::OSC_LOW_POWER_RC];
        wdt_ctrl_pkg::SRC_FAST_RC:
          wdt_tick = osc_rise[wdt_ctrl_pkg::OSC_FAST_RC];
        wdt_ctrl_pkg::SRC_SYSTEM_CLOCK:
          wdt_tick = 1'b1;
        default:
          wdt_tick = 1'b0;
      endcase
    end
  end

  // Power of two timeout; sleep and idle use their own postscaler.
  assign limit = low_power ? period_limit(sleep_postscaler) // RULE6
                           : period_limit(run_postscaler);  // RULE4

  // Bus decode: the write lands at the edge where pready is sampled high.
  assign bus_access = psel_i & penable_i & ~pready_o;
  assign wr_fire    = psel_i & penable_i & pready_o & pwrite_i;
  assign key_write  = wr_fire & (paddr_i == wdt_ctrl_pkg::CLEAR_KEY_ADDR)
                    & (pstrb_i == wdt_ctrl_pkg::HALF_WORD_STRB)
                    & (pwdata_i[15:0] == wdt_ctrl_pkg::CLEAR_KEY_VALUE);
  // A key in the first half of the period is an illegal early clear.
  assign early_clear = key_write & running & window_mode_enable
                     & (count < {1'b0, limit[31:1]});
  assign key_restart = key_write & ~early_clear; // RULE11 RULE16
  assign timeout     = running & wdt_tick & (count == limit) & ~key_write;

  // Enable and window bits; the fuse halves are OR-ed in on read.
  assign running            = fuse_enable | sw_enable;   // RULE2
  assign window_mode_enable = fuse_window | sw_window;   // RULE8 RULE9
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sw_enable <= 1'b0;
      sw_window <= 1'b0;
    end else if (wr_fire & (paddr_i == wdt_ctrl_pkg::CTRL_LOW_ADDR)
                 & pstrb_i[1]) begin
      // Clearing only drops the software half; a fuse enable stays.
      sw_enable <= pwdata_i[wdt_ctrl_pkg::ENABLE_BIT]; // RULE1 RULE2
      if (pstrb_i[0]) begin
        sw_window <= pwdata_i[wdt_ctrl_pkg::WINDOW_BIT]; // RULE9
      end
    end else if (wr_fire & (paddr_i == wdt_ctrl_pkg::CTRL_LOW_ADDR)
                 & pstrb_i[0]) begin
      sw_window <= pwdata_i[wdt_ctrl_pkg::WINDOW_BIT]; // RULE9
    end
  end

  // Watchdog counter; stopping the watchdog also restarts it from zero.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i | ~running | key_restart) begin
      count <= wdt_ctrl_pkg::COUNT_RESET; // RULE11
    end else if (wdt_tick) begin
      count <= (count >= limit) ? wdt_ctrl_pkg::COUNT_RESET
                                : count + 32'h0000_0001; // RULE4
    end
  end

  // Sticky interrupt status: a new event wins over a write-one clear.
  always_comb begin
    irq_events = '0;
    irq_events[wdt_ctrl_pkg::IRQ_TIMEOUT_BIT] = timeout & ~low_power;
    irq_events[wdt_ctrl_pkg::IRQ_WAKE_BIT]    = timeout & low_power;
    irq_events[wdt_ctrl_pkg::IRQ_EARLY_BIT]   = early_clear;
    next_irq_status = irq_status | irq_events;
    if (wr_fire & (paddr_i == wdt_ctrl_pkg::IRQ_STATUS_ADDR)) begin
      next_irq_status = (irq_status & ~pwdata_i[IRQ_W-1:0]) | irq_events;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_status <= '0;
    end else begin
      irq_status <= next_irq_status;
    end
  end

  // Interrupt mask, software read and write.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      irq_mask <= wdt_ctrl_pkg::IRQ_MASK_RESET;
    end else if (wr_fire & (paddr_i == wdt_ctrl_pkg::IRQ_MASK_ADDR)) begin
      irq_mask <= pwdata_i[IRQ_W-1:0];
    end
  end

  // The reset cause flag is cleared only by power-on reset or software,
  // since the device reset that this block requests leaves it alone.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      timeout_reset_flag <= 1'b0;
    end else if (timeout & ~low_power | early_clear) begin
      timeout_reset_flag <= 1'b1; // RULE14
    end else if (wr_fire & (paddr_i == wdt_ctrl_pkg::RESET_CAUSE_ADDR)
                 & pwdata_i[wdt_ctrl_pkg::TIMEOUT_FLAG_BIT]) begin
      timeout_reset_flag <= 1'b0;
    end
  end

  // Read mux; unimplemented and reserved bits read zero.
  always_comb begin
    next_rdata  = 32'h0000_0000;
    next_slverr = 1'b0;
    case (paddr_i)
      wdt_ctrl_pkg::CTRL_LOW_ADDR: begin
        next_rdata[wdt_ctrl_pkg::ENABLE_BIT] = running; // RULE3 RULE12
        next_rdata[wdt_ctrl_pkg::RUN_DIV_LSB +: 5]   = run_postscaler;
        next_rdata[wdt_ctrl_pkg::CLK_SRC_LSB +: 2]   = run_clock_source;
        next_rdata[wdt_ctrl_pkg::SLEEP_DIV_LSB +: 5] = sleep_postscaler;
        next_rdata[wdt_ctrl_pkg::WINDOW_BIT] = window_mode_enable;
      end
      wdt_ctrl_pkg::CLEAR_KEY_ADDR:
        next_rdata = 32'h0000_0000; // RULE16
      wdt_ctrl_pkg::IRQ_STATUS_ADDR:
        next_rdata[IRQ_W-1:0] = irq_status;
      wdt_ctrl_pkg::IRQ_MASK_ADDR:
        next_rdata[IRQ_W-1:0] = irq_mask;
      wdt_ctrl_pkg::RESET_CAUSE_ADDR:
        next_rdata[wdt_ctrl_pkg::TIMEOUT_FLAG_BIT] = timeout_reset_flag;
      default:
        next_slverr = 1'b1;
    endcase
  end

  // One wait state per transfer keeps read data registered. Software
  // must not touch the block right after clearing enable. RULE10
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= bus_access;
      pslverr_o <= bus_access & next_slverr;
      prdata_o  <= (bus_access & ~pwrite_i) ? next_rdata : 32'h0000_0000;
    end
  end

  // Registered results; an early window clear resets like a timeout.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      watchdog_running_o <= 1'b0;
      device_reset_o     <= 1'b0;
      wake_o             <= 1'b0;
      irq_o              <= 1'b0;
    end else begin
      watchdog_running_o <= running;
      device_reset_o     <= (timeout & ~low_power) | early_clear;
      wake_o             <= timeout & low_power;
      irq_o              <= |(next_irq_status & irq_mask);
    end
  end

  chk_sw_enable_start: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_fire && paddr_i == wdt_ctrl_pkg::CTRL_LOW_ADDR && pstrb_i[1]
    && pwdata_i[15] |=> running ##1 watchdog_running_o)
    else $error("software enable did not start watchdog"); // RULE1
  chk_fuse_no_stop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    fuse_enable |-> running)
    else $error("fuse enabled watchdog was stopped"); // RULE2
  chk_enable_readback: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    bus_access && !pwrite_i && paddr_i == wdt_ctrl_pkg::CTRL_LOW_ADDR
    |=> prdata_o[15] == $past(running) && prdata_o[14:13] == 2'h0)
    else $error("enable read back wrong"); // RULE3 RULE12
  chk_count_bound: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    running && wdt_tick |=> count <= $past(limit))
    else $error("counter passed postscaler limit"); // RULE4
  chk_fuse_stable: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    $stable(run_postscaler) && $stable(sleep_postscaler)
    && $stable(run_clock_source))
    else $error("fuse mirror changed after reset"); // RULE7
  chk_window_forced: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    fuse_window |-> window_mode_enable)
    else $error("window fuse not forcing window mode"); // RULE9
  chk_key_restart: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    key_write && !early_clear |=> count == 32'h0000_0000)
    else $error("valid key did not restart counter"); // RULE11
  chk_bad_key_keep: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    wr_fire && paddr_i == wdt_ctrl_pkg::CLEAR_KEY_ADDR && !key_write
    && running && !wdt_tick |=> $stable(count))
    else $error("bad key changed counter"); // RULE16
  chk_sleep_source: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    low_power |-> wdt_tick == osc_rise[wdt_ctrl_pkg::OSC_LOW_POWER_RC])
    else $error("sleep tick not from low power oscillator"); // RULE13
  chk_timeout_flag: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
    timeout && !low_power |=> timeout_reset_flag && device_reset_o)
    else $error("timeout reset did not set flag"); // RULE14

endmodule : watchdog_control_registers
`default_nettype wire

// [hw/wdt_ctrl_pkg.sv]
/*
  Constants shared by the watchdog control register block: register
  byte offsets, field positions, reset values and the clear key.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
package wdt_ctrl_pkg;

  // Byte offsets of the registers.
  localparam logic [11:0] CTRL_LOW_ADDR    = 12'h000;
  localparam logic [11:0] CLEAR_KEY_ADDR   = 12'h004;
  localparam logic [11:0] IRQ_STATUS_ADDR  = 12'h008;
  localparam logic [11:0] IRQ_MASK_ADDR    = 12'h00c;
  localparam logic [11:0] RESET_CAUSE_ADDR = 12'h010;

  // Field positions in the low control register.
  localparam int ENABLE_BIT    = 15;
  localparam int RUN_DIV_LSB   = 8;
  localparam int CLK_SRC_LSB   = 6;
  localparam int SLEEP_DIV_LSB = 1;
  localparam int WINDOW_BIT    = 0;

  // Interrupt status and mask bit positions.
  localparam int IRQ_TIMEOUT_BIT = 0;
  localparam int IRQ_WAKE_BIT    = 1;
  localparam int IRQ_EARLY_BIT   = 2;
  localparam int IRQ_WIDTH       = 3;

  // Bit of the reset cause register that flags a watchdog reset.
  localparam int TIMEOUT_FLAG_BIT = 0;

  // Key that restarts the counter, and the byte enables of a 16-bit write.
  localparam logic [15:0] CLEAR_KEY_VALUE = 16'h5743;
  localparam logic [3:0]  HALF_WORD_STRB  = 4'h3;

  // Reset values.
  localparam logic [IRQ_WIDTH-1:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [31:0]          COUNT_RESET    = 32'h0000_0000;

  // Run-mode clock source encodings.
  localparam logic [1:0] SRC_SYSTEM_CLOCK = 2'h0;
  localparam logic [1:0] SRC_RESERVED     = 2'h1;
  localparam logic [1:0] SRC_FAST_RC      = 2'h2;
  localparam logic [1:0] SRC_LOW_POWER_RC = 2'h3;

  // Oscillator inputs sampled on the bus clock.
  localparam int OSC_LOW_POWER_RC = 0;
  localparam int OSC_FAST_RC      = 1;
  localparam int OSC_COUNT        = 2;

endpackage : wdt_ctrl_pkg

// [hw/wdt_osc_edge.sv]
/*
  Synchroniser and rising edge detector for one oscillator pin.
  Assumes the oscillator runs well below half the bus clock rate.
*/
`timescale 1ns/100ps
`default_nettype none
module wdt_osc_edge (
  // Clock and reset.
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  // Oscillator pin and its edge pulse.
  input  wire logic osc_i,
  output logic      rise_o
);

  logic sync_first;
  logic sync_second;
  logic sync_last;

  // The first stage feeds only the second, so a metastable value never
  // reaches the edge logic.
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      sync_first  <= 1'b0;
      sync_second <= 1'b0;
      sync_last   <= 1'b0;
      rise_o      <= 1'b0;
    end else begin
      sync_first  <= osc_i;
      sync_second <= sync_first;
      sync_last   <= sync_second;
      rise_o      <= sync_second & ~sync_last;
    end
  end

endmodule : wdt_osc_edge
`default_nettype wire
